// [hw/dcd_core.sv]
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dcd_defs.svh"
module dcd_core
   import dcd_pkg::*;
#(
   parameter int EXT_WAIT = `DCD_EXT_WAIT
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Maskable interrupt request pins.
   input  wire logic [6:0]  irq_req,
   // Core state.
   output logic             busy
);
   localparam int WW = (EXT_WAIT < 1) ? 1 : $clog2(EXT_WAIT + 1);

   dcd_state_t  state_ff;
   logic [WW-1:0] wcnt_ff;
   logic [31:0] cmd_ff;
   logic [31:0] acc_ff;
   logic [31:0] prod_ff;
   logic [31:0] prdata_ff;
   logic [15:0] din_ff;
   logic [15:0] ea_ff;
   logic [15:0] pc_ff;
   logic [15:0] pf_ff;
   logic [8:0]  dp_ff;
   logic [2:0]  arp_ff;
   logic [1:0]  pm_ff;
   logic        c_ff;
   logic        tc_ff;
   logic        cnf_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        busy_ff;
   logic [6:0]  mask_ff;
   logic [6:0]  flag_ff;
   logic [6:0]  irq_s1_ff;
   logic [6:0]  irq_s2_ff;
   logic [4:0]  vec_ff;
   logic [15:0] ptr_ff [0:`DCD_NPTR-1];
   logic [15:0] b0_mem [0:`DCD_B01_WORDS-1];
   logic [15:0] b1_mem [0:`DCD_B01_WORDS-1];
   logic [15:0] b2_mem [0:`DCD_B2_WORDS-1];

   dcd_op_t     op;
   logic        ind;
   logic [15:0] cur_ptr;
   logic [15:0] ptr0;
   logic [15:0] ea;
   logic [15:0] opnd;
   logic [15:0] step;
   logic [15:0] nxt_ptr;
   logic        hit0;
   logic        hit1;
   logic        hit2;
   logic        phit0;
   logic        memop;
   logic        progop;
   logic        ext_acc;
   logic        do_exec;
   logic [31:0] scaled;
   logic [31:0] alu_b;
   logic [32:0] alu_sum;
   logic [33:0] mul_full;
   logic [31:0] mul_res;
   logic [6:0]  pend;
   logic [6:0]  clr;
   logic        apb_acc;
   logic        apb_done;
   logic        wr_done;
   logic        stall;
   logic [31:0] rd_mux;
   logic        unmapped;

   function automatic logic [31:0] in_scale(input logic [15:0] d, input logic sgn,
                                            input logic [4:0] sh);
      logic [31:0] x;
      logic [4:0]  s;
      x = {{16{sgn & d[15]}}, d};
      s = (sh > `DCD_MAX_SH) ? `DCD_MAX_SH : sh;
      return x << s;
   endfunction

   function automatic logic [31:0] p_scale(input logic [31:0] p, input logic [1:0] m);
      case (m)
         2'h1: return p << 1;
         2'h2: return p << 4;
         2'h3: return 32'($signed(p) >>> 6);
         default: return p;
      endcase
   endfunction

   function automatic logic [2:0] low_idx(input logic [6:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (v[i]) r = 3'(i);
      end
      return r;
   endfunction

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign busy    = busy_ff;

   // Operand address formation and memory map.
   assign op      = dcd_op_t'(cmd_ff[`DCD_F_OP]);
   assign ind     = cmd_ff[`DCD_F_IND];
   assign cur_ptr = ptr_ff[arp_ff];
   assign ptr0    = ptr_ff[0];
   assign ea      = ind ? cur_ptr : {dp_ff, cmd_ff[`DCD_F_OFS]};
   assign hit0    = !cnf_ff && ea[15:8] == `DCD_B0_DBASE;
   assign hit1    = ea[15:8] == `DCD_B1_BASE;
   assign hit2    = ea[15:5] == `DCD_B2_BASE;
   assign phit0   = cnf_ff && cur_ptr[15:8] == `DCD_B0_PBASE;
   assign memop   = op inside {OP_LST0, OP_LST1, OP_LAC, OP_ADD, OP_ADDC, OP_SUB,
                               OP_MPY, OP_SACL};
   assign progop  = op inside {OP_PRD, OP_PWR};
   assign ext_acc = memop ? !(hit0 || hit1 || hit2) : (progop && !phit0);
   assign do_exec = state_ff == ST_EXEC && (!ext_acc || wcnt_ff == WW'(EXT_WAIT));

   // Operands that miss on-chip RAM come from the external data word.
   always_comb begin
      if (progop) opnd = phit0 ? b0_mem[cur_ptr[7:0]] : din_ff;
      else if (hit0) opnd = b0_mem[ea[7:0]];
      else if (hit1) opnd = b1_mem[ea[7:0]];
      else if (hit2) opnd = b2_mem[ea[4:0]];
      else opnd = din_ff;
   end

   assign scaled = in_scale(opnd, cmd_ff[`DCD_F_SGN], cmd_ff[`DCD_F_SH]);
   assign alu_b  = (op == OP_APAC) ? p_scale(prod_ff, pm_ff) : scaled;

   always_comb begin
      case (op)
         OP_SUB:  alu_sum = {1'b0, acc_ff} + {1'b0, ~alu_b} + 33'h0_0000_0001;
         OP_ADDC: alu_sum = {1'b0, acc_ff} + {1'b0, alu_b} + {32'h0000_0000, c_ff};
         default: alu_sum = {1'b0, acc_ff} + {1'b0, alu_b};
      endcase
   end

   assign mul_full = $signed({cmd_ff[`DCD_F_SGN] & opnd[15], opnd})
                   * $signed({cmd_ff[`DCD_F_SGN] & din_ff[15], din_ff});
   assign mul_res  = mul_full[31:0];

   always_comb begin
      case (dcd_upd_t'(cmd_ff[`DCD_F_UPD]))
         PU_INC:  step = 16'h0001;
         PU_DEC:  step = 16'hFFFF;
         PU_IDX:  step = ptr0;
         default: step = 16'h0000;
      endcase
   end
   assign nxt_ptr = cur_ptr + step;

   // APB slave: one wait state, more for a command write while the core is busy, then pready for one cycle.
   assign apb_acc  = psel && penable && !pready_ff;
   assign apb_done = psel && penable && pready_ff;
   assign wr_done  = apb_done && pwrite && !pslverr_ff;
   assign stall    = pwrite && paddr == `DCD_A_CMD && state_ff != ST_IDLE;

   always_comb begin
      rd_mux   = 32'h0000_0000;
      unmapped = 1'b0;
      if (paddr == `DCD_A_CMD) rd_mux = cmd_ff;
      else if (paddr == `DCD_A_DIN) rd_mux[15:0] = din_ff;
      else if (paddr == `DCD_A_ACC) rd_mux = acc_ff;
      else if (paddr == `DCD_A_ST0) begin
         rd_mux[`DCD_F_ARP] = arp_ff;
         rd_mux[`DCD_F_DP]  = dp_ff;
      end else if (paddr == `DCD_A_ST1) begin
         rd_mux[`DCD_F_CNF] = cnf_ff;
         rd_mux[`DCD_F_TC]  = tc_ff;
         rd_mux[`DCD_F_C]   = c_ff;
         rd_mux[`DCD_F_PM]  = pm_ff;
      end else if (paddr == `DCD_A_EA) rd_mux[15:0] = ea_ff;
      else if (paddr == `DCD_A_PROD) rd_mux = prod_ff;
      else if (paddr == `DCD_A_MASK) rd_mux[6:0] = mask_ff;
      else if (paddr == `DCD_A_FLAG) rd_mux[6:0] = flag_ff;
      else if (paddr == `DCD_A_GSR) rd_mux = 32'h0000_0000;
      else if (paddr == `DCD_A_VEC) rd_mux[4:0] = vec_ff;
      else if (paddr == `DCD_A_STAT) begin
         rd_mux[0] = busy_ff;
         rd_mux[1] = |pend;
         rd_mux[2] = acc_ff == 32'h0000_0000;
         rd_mux[3] = acc_ff[31];
      end else if (paddr == `DCD_A_PC) rd_mux = {pf_ff, pc_ff};
      else if ((paddr & `DCD_PTR_MSK) == `DCD_A_PTR) rd_mux[15:0] = ptr_ff[paddr[4:2]];
      else unmapped = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (apb_acc && !stall) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= unmapped;
         prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Command sequencing with instruction prefetch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         wcnt_ff  <= '0;
         cmd_ff   <= 32'h0000_0000;
         busy_ff  <= 1'b0;
         pc_ff    <= 16'h0000;
         pf_ff    <= 16'h0000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (wr_done && paddr == `DCD_A_CMD) begin
                  cmd_ff   <= pwdata;
                  state_ff <= ST_EXEC;
                  busy_ff  <= 1'b1;
                  wcnt_ff  <= '0;
                  pc_ff    <= pf_ff;
                  pf_ff    <= pf_ff + 16'h0001;
               end
            end
            ST_EXEC: begin
               if (do_exec) begin
                  state_ff <= ST_IDLE;
                  busy_ff  <= 1'b0;
               end else begin
                  wcnt_ff <= wcnt_ff + WW'(1);
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) acc_ff <= 32'h0000_0000;
      else if (wr_done && paddr == `DCD_A_ACC) acc_ff <= pwdata;
      else if (do_exec) begin
         case (op)
            OP_LAC:                           acc_ff <= scaled;
            OP_ADD, OP_ADDC, OP_SUB, OP_APAC: acc_ff <= alu_sum[31:0];
            OP_SFL:                           acc_ff <= {acc_ff[30:0], 1'b0};
            OP_SFR:                           acc_ff <= {1'b0, acc_ff[31:1]};
            OP_ROL:                           acc_ff <= {acc_ff[30:0], c_ff};
            OP_ROR:                           acc_ff <= {c_ff, acc_ff[31:1]};
            OP_PRD:                           acc_ff <= {16'h0000, opnd};
            default:                          acc_ff <= acc_ff;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp_ff  <= 9'h000;
         arp_ff <= 3'h0;
         c_ff   <= 1'b0;
         tc_ff  <= 1'b0;
         cnf_ff <= 1'b0;
         pm_ff  <= 2'h0;
      end else if (do_exec) begin
         case (op)
            OP_LDP: dp_ff <= din_ff[`DCD_F_DP];
            OP_LST0: begin
               dp_ff  <= opnd[`DCD_F_DP];
               arp_ff <= opnd[`DCD_F_ARP];
            end
            OP_LST1: begin
               cnf_ff <= opnd[`DCD_F_CNF];
               tc_ff  <= opnd[`DCD_F_TC];
               c_ff   <= opnd[`DCD_F_C];
               pm_ff  <= opnd[`DCD_F_PM];
            end
            OP_ADD, OP_ADDC, OP_SUB, OP_APAC: c_ff <= alu_sum[32];
            OP_SFL, OP_ROL: c_ff <= acc_ff[31];
            OP_SFR, OP_ROR: c_ff <= acc_ff[0];
            OP_CMPR: tc_ff <= cur_ptr == ptr0;
            default: tc_ff <= tc_ff;
         endcase
         if (ind && op != OP_LST0) arp_ff <= cmd_ff[`DCD_F_NARP];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `DCD_NPTR; i++) ptr_ff[i] <= 16'h0000;
      end else if (wr_done && (paddr & `DCD_PTR_MSK) == `DCD_A_PTR) begin
         ptr_ff[paddr[4:2]] <= pwdata[15:0];
      end else if (do_exec && ind) begin
         ptr_ff[arp_ff] <= nxt_ptr;
      end
   end

   // On-chip dual-access blocks; external stores are dropped.
   always_ff @(posedge pclk) begin
      if (do_exec && op == OP_SACL) begin
         if (hit0) b0_mem[ea[7:0]] <= acc_ff[15:0];
         else if (hit1) b1_mem[ea[7:0]] <= acc_ff[15:0];
         else if (hit2) b2_mem[ea[4:0]] <= acc_ff[15:0];
      end
      if (do_exec && op == OP_PWR && phit0) b0_mem[cur_ptr[7:0]] <= acc_ff[15:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_ff <= 32'h0000_0000;
         din_ff  <= 16'h0000;
         ea_ff   <= 16'h0000;
      end else begin
         if (do_exec && op == OP_MPY) prod_ff <= mul_res;
         if (wr_done && paddr == `DCD_A_DIN) din_ff <= pwdata[15:0];
         if (do_exec) ea_ff <= progop ? cur_ptr : ea;
      end
   end

   // Interrupt flags: a new request beats a clear in the same cycle.
   assign pend = flag_ff & mask_ff;
   always_comb begin
      clr = 7'h00;
      if (wr_done && paddr == `DCD_A_FLAG) clr = pwdata[6:0];
      if (do_exec && op == OP_IACK && |pend) clr[low_idx(pend)] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_s1_ff <= 7'h00;
         irq_s2_ff <= 7'h00;
         flag_ff   <= 7'h00;
         mask_ff   <= 7'h00;
         vec_ff    <= 5'h00;
      end else begin
         irq_s1_ff <= irq_req;
         irq_s2_ff <= irq_s1_ff;
         flag_ff   <= (flag_ff & ~clr) | irq_s2_ff;
         if (wr_done && paddr == `DCD_A_MASK) mask_ff <= pwdata[6:0];
         if (do_exec && op == OP_TRAP) vec_ff <= cmd_ff[`DCD_F_VEC];
         else if (do_exec && op == OP_IACK && |pend) vec_ff <= 5'(low_idx(pend)) + 5'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_dp_only_ldp_lst;
      $changed(dp_ff) |-> $past(do_exec) && $past(op) inside {OP_LDP, OP_LST0};
   endproperty
   a_dp_only_ldp_lst: assert property (p_dp_only_ldp_lst)
      else $error("page pointer changed without a load command");
   property p_direct_addr;
      do_exec && !ind && !progop && op != OP_SACL |=> ea_ff[15:7] == $past(dp_ff);
   endproperty
   a_direct_addr: assert property (p_direct_addr)
      else $error("direct address page bits do not match page pointer");
   property p_pointer_arith_unit_inc;
      do_exec && ind && cmd_ff[`DCD_F_UPD] == PU_INC && cmd_ff[`DCD_F_NARP] == arp_ff
         && !(wr_done && (paddr & `DCD_PTR_MSK) == `DCD_A_PTR)
      |=> cur_ptr == $past(cur_ptr) + 16'h0001;
   endproperty
   a_pointer_arith_unit_inc: assert property (p_pointer_arith_unit_inc)
      else $error("pointer did not advance by one");
   property p_cmpr;
      do_exec && op == OP_CMPR |=> tc_ff == ($past(cur_ptr) == $past(ptr0));
   endproperty
   a_cmpr: assert property (p_cmpr)
      else $error("compare flag wrong");
   property p_sfl_carry;
      do_exec && op == OP_SFL |=> c_ff == $past(acc_ff[31]);
   endproperty
   a_sfl_carry: assert property (p_sfl_carry)
      else $error("carry not taken from shifted-out bit");
   property p_one_cycle;
      state_ff == ST_EXEC && !ext_acc |=> state_ff == ST_IDLE && !busy_ff;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("internal command took more than one cycle");
   property p_ext_slow;
      state_ff == ST_EXEC && ext_acc && wcnt_ff == '0 |=> state_ff == ST_EXEC;
   endproperty
   a_ext_slow: assert property (p_ext_slow)
      else $error("external operand fetch added no cycle");
   property p_b0_map;
      cnf_ff && memop && ea[15:8] == `DCD_B0_DBASE |-> ext_acc;
   endproperty
   a_b0_map: assert property (p_b0_map)
      else $error("block zero in data space while config bit set");
   property p_flag_set;
      irq_s2_ff != 7'h00 |=> (flag_ff & $past(irq_s2_ff)) == $past(irq_s2_ff);
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("latched request did not set its flag");
   property p_mul;
      do_exec && op == OP_MPY |=> prod_ff == $past(mul_res);
   endproperty
   a_mul: assert property (p_mul)
      else $error("product not stored in one cycle");
   property p_gsr_zero;
      pready_ff && psel && !pwrite && paddr == `DCD_A_GSR |-> prdata_ff == 32'h0000_0000;
   endproperty
   a_gsr_zero: assert property (p_gsr_zero)
      else $error("reserved global-size register read nonzero");

   c_ext_fetch: cover property (state_ff == ST_EXEC && ext_acc ##1 state_ff == ST_IDLE);
   c_iack:      cover property (do_exec && op == OP_IACK && |pend);
   c_stall:     cover property (psel && penable && stall);
endmodule

// [shared/dcd_defs.svh]
`ifndef DCD_DEFS_SVH
`define DCD_DEFS_SVH
// Function
// - Direct address is the nine page bits above seven instruction offset bits.
// - Direct addressing sees data memory as 512 pages of 128 words.
// - Indirect addressing uses the selected pointer register as operand address.
// - Eight 16-bit pointer registers reach the whole data space.
// - Pointer select values 0 to 7 choose pointer registers zero to seven.
// - Pointer unit is a 16-bit unsigned adder writing back to pointers.
// - Pointer zero is the step above one and the compare value.
// - Accumulator is 32 bits, takes results, feeds operations, shifts and rotates.
// - Carry lives in status one, feeds extended adds, tests, shifts, rotates.
// - Main arithmetic unit is 32 bits and finishes in one cycle.
// - Arithmetic unit adds scaler output to accumulator and reports status.
// - Config bit zero maps block zero to data, else to program space.
// - Blocks one and two sit in data space at 0300-03FF and 0060-007F.
// - Blocks zero and one hold 256 words, block two 32 words.
// - Page pointer changes only by load-status and load-page commands.
// - Global-size register is reserved.
// - Mask register enables each of seven maskable interrupts separately.
// - Seven-bit flag register sets a bit for each latched request.
// - Thirty-two trap vectors are reachable by hardware or software.
// - Input scaler shifts 16-bit data left 0 to 16 into 32 bits.
// - Multiplier gives a 32-bit signed or unsigned product in one cycle.
// - Next command is prefetched; external operand fetch adds cycles.
`define DCD_A_CMD     12'h000
`define DCD_A_DIN     12'h004
`define DCD_A_ACC     12'h008
`define DCD_A_ST0     12'h00C
`define DCD_A_ST1     12'h010
`define DCD_A_EA      12'h014
`define DCD_A_PROD    12'h018
`define DCD_A_MASK    12'h01C
`define DCD_A_FLAG    12'h020
`define DCD_A_GSR     12'h024
`define DCD_A_VEC     12'h028
`define DCD_A_STAT    12'h02C
`define DCD_A_PC      12'h030
`define DCD_A_PTR     12'h040
`define DCD_PTR_MSK   12'hFE0
`define DCD_F_OP      4:0
`define DCD_F_IND     5
`define DCD_F_OFS     12:6
`define DCD_F_VEC     10:6
`define DCD_F_NARP    15:13
`define DCD_F_SGN     16
`define DCD_F_SH      21:17
`define DCD_F_UPD     23:22
`define DCD_F_ARP     15:13
`define DCD_F_DP      8:0
`define DCD_F_CNF     12
`define DCD_F_TC      11
`define DCD_F_C       9
`define DCD_F_PM      1:0
`define DCD_B0_DBASE  8'h02
`define DCD_B0_PBASE  8'hFE
`define DCD_B1_BASE   8'h03
`define DCD_B2_BASE   11'h003
`define DCD_B01_WORDS 256
`define DCD_B2_WORDS  32
`define DCD_NPTR      8
`define DCD_MAX_SH    5'h10
`define DCD_EXT_WAIT  2
`endif

// [shared/dcd_pkg.sv]
package dcd_pkg;
   typedef enum logic [4:0] {
      OP_NOP  = 5'h00, OP_LDP  = 5'h01, OP_LST0 = 5'h02, OP_LST1 = 5'h03,
      OP_LAC  = 5'h04, OP_ADD  = 5'h05, OP_ADDC = 5'h06, OP_SUB  = 5'h07,
      OP_MPY  = 5'h08, OP_APAC = 5'h09, OP_SFL  = 5'h0A, OP_SFR  = 5'h0B,
      OP_ROL  = 5'h0C, OP_ROR  = 5'h0D, OP_SACL = 5'h0E, OP_CMPR = 5'h0F,
      OP_TRAP = 5'h10, OP_IACK = 5'h11, OP_PRD  = 5'h12, OP_PWR  = 5'h13,
      OP_MAR  = 5'h14
   } dcd_op_t;
   typedef enum logic [1:0] {
      PU_NONE = 2'b00, PU_INC = 2'b01, PU_DEC = 2'b10, PU_IDX = 2'b11
   } dcd_upd_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0, ST_EXEC = 1'b1
   } dcd_state_t;
endpackage

// [bench/dcd_irq_src.sv]
`timescale 1ns/1ps
module dcd_irq_src (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // One-cycle strobes from the bench.
   input  wire logic [6:0] fire,
   // Request level pins.
   output logic      [6:0] irq_req
);
   logic [6:0] dly_ff;
   // Each strobe becomes a two-cycle level so that the synchroniser sees it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_ff  <= 7'h00;
         irq_req <= 7'h00;
      end else begin
         dly_ff  <= fire;
         irq_req <= fire | dly_ff;
      end
   end
endmodule

// [bench/dcd_core_bench.sv]
`timescale 1ns/1ps
module dcd_core_bench;
   import dcd_pkg::*;
   localparam int EW = 3;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [6:0]  fire = 7'h00;
   logic [6:0]  irq_req;
   logic        busy;
   int          errors = 0;
   int          checks_done = 0;
   int          seed = 35103;

   dcd_core #(.EXT_WAIT(EW)) u_dcd_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .busy(busy));
   dcd_irq_src u_dcd_irq_src (
      .pclk(pclk), .presetn(presetn), .fire(fire), .irq_req(irq_req));

   initial begin
      forever #2.5 pclk = ~pclk;
   end

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50 && pready !== 1'b1; n++) begin
         @(posedge pclk);
      end
      if (n == 50) begin
         errors++;
         $display("ERROR t=%0t bus transfer timed out", $time);
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
   endtask

   // Returns the number of cycles that busy stood high.
   task automatic cmd(input logic [31:0] c, output int n);
      wr(12'h000, c);
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (busy !== 1'b1) break;
      end
      if (n == 50) begin
         errors++;
         $display("ERROR t=%0t command timed out", $time);
         close_out();
      end
   endtask

   function automatic logic [31:0] cw(input logic [4:0] op, input logic ind,
      input logic [6:0] of, input logic [2:0] np, input logic sg, input logic [4:0] sh,
      input logic [1:0] up);
      return {8'h00, up, sh, sg, np, of, ind, op};
   endfunction

   function automatic logic [31:0] scale(input logic [15:0] d, input logic sg,
                                         input logic [4:0] sh);
      logic [31:0] v;
      v = sg ? {{16{d[15]}}, d} : {16'h0000, d};
      return v << ((sh > 5'd16) ? 5'd16 : sh);
   endfunction

   initial begin
      logic        [31:0] r, acc, d, pr;
      logic signed [31:0] sx;
      logic        [32:0] s;
      logic        [15:0] p [8];
      logic        [15:0] ta [9];
      logic        [8:0]  pg;
      logic        [6:0]  of, m;
      logic        [4:0]  sh;
      logic        [2:0]  k;
      logic               sg, e;
      int                 i, n;
      ta = '{16'h0060, 16'h007F, 16'h0300, 16'h03FF, 16'h0250, 16'h02FF,
             16'h005F, 16'h0080, 16'h0400};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h008, 32'h0000_0000);
      rd(12'h00C, 32'h0000_0000);
      rd(12'h010, 32'h0000_0000);
      rd(12'h01C, 32'h0000_0000);
      rd(12'h020, 32'h0000_0000);
      wr(12'h024, 32'hFFFF_FFFF);
      rd(12'h024, 32'h0000_0000);
      apb(1'b1, 12'h100, 32'h0000_0001, r, e);
      chk(32'(e), 32'h0000_0001);
      for (i = 0; i < 6; i++) begin
         pg = 9'h100 | 9'($random(seed));
         of = 7'($random(seed));
         d = $random(seed);
         sh = (i == 0) ? 5'd16 : (i == 1) ? 5'd31 : 5'($random(seed));
         sg = 1'($random(seed));
         wr(12'h004, {23'h0, pg});
         cmd(cw(OP_LDP, 1'b0, 7'h00, 3'd0, 1'b0, 5'd0, 2'd0), n);
         rd(12'h00C, {23'h0, pg});
         wr(12'h004, d);
         cmd(cw(OP_LAC, 1'b0, of, 3'd0, sg, sh, 2'd0), n);
         chk(32'(n), 32'(1 + EW));
         rd(12'h014, {16'h0000, pg, of});
         acc = scale(d[15:0], sg, sh);
         rd(12'h008, acc);
         cmd(cw(OP_ADD, 1'b0, of, 3'd0, sg, sh, 2'd0), n);
         s = {1'b0, acc} + {1'b0, acc};
         rd(12'h008, s[31:0]);
         rd(12'h010, {22'h0, s[32], 9'h000});
         cmd(cw(OP_MPY, 1'b0, of, 3'd0, sg, 5'd0, 2'd0), n);
         sx = $signed(d[15:0]);
         pr = sg ? 32'(sx * sx) : {16'h0000, d[15:0]} * {16'h0000, d[15:0]};
         rd(12'h018, pr);
      end
      for (i = 0; i < 8; i++) begin
         p[i] = (i == 1) ? 16'hFFFF : 16'h8000 | 16'($random(seed));
         wr(12'h040 + 12'(4 * i), {16'h0000, p[i]});
         rd(12'h040 + 12'(4 * i), {16'h0000, p[i]});
      end
      for (i = 0; i < 8; i++) begin
         k = 3'(i);
         cmd(cw(OP_MAR, 1'b1, 7'h00, k, 1'b0, 5'd0, 2'd0), n);
         cmd(cw(OP_LAC, 1'b1, 7'h00, k, 1'b0, 5'd0, 2'(i)), n);
         rd(12'h014, {16'h0000, p[k]});
         case (i % 4)
            1: p[k] = p[k] + 16'h0001;
            2: p[k] = p[k] - 16'h0001;
            3: p[k] = p[k] + p[0];
            default: ;
         endcase
         rd(12'h040 + 12'(4 * i), {16'h0000, p[k]});
         rd(12'h00C, {16'h0000, k, 4'h0, pg});
         cmd(cw(OP_CMPR, 1'b0, 7'h00, 3'd0, 1'b0, 5'd0, 2'd0), n);
         apb(1'b0, 12'h010, 32'h0000_0000, r, e);
         chk(32'(r[11]), 32'(p[k] == p[0]));
      end
      cmd(cw(OP_MAR, 1'b1, 7'h00, 3'd1, 1'b0, 5'd0, 2'd0), n);
      for (i = 0; i < 9; i++) begin
         d = $random(seed);
         wr(12'h044, {16'h0000, ta[i]});
         wr(12'h008, d);
         cmd(cw(OP_SACL, 1'b1, 7'h00, 3'd1, 1'b0, 5'd0, 2'd0), n);
         chk(32'(n), (i < 6) ? 32'd1 : 32'(1 + EW));
         wr(12'h004, ~d);
         cmd(cw(OP_LAC, 1'b1, 7'h00, 3'd1, 1'b0, 5'd0, 2'd0), n);
         rd(12'h008, {16'h0000, (i < 6) ? d[15:0] : ~d[15:0]});
      end
      wr(12'h004, 32'h0000_1000);
      cmd(cw(OP_LST1, 1'b0, of, 3'd1, 1'b0, 5'd0, 2'd0), n);
      apb(1'b0, 12'h010, 32'h0000_0000, r, e);
      chk(32'(r[12]), 32'h0000_0001);
      wr(12'h044, 32'h0000_0250);
      wr(12'h004, 32'h0000_1234);
      cmd(cw(OP_LAC, 1'b1, 7'h00, 3'd1, 1'b0, 5'd0, 2'd0), n);
      rd(12'h008, 32'h0000_1234);
      m = 7'($random(seed)) | 7'h01;
      wr(12'h01C, {25'h0, m});
      rd(12'h01C, {25'h0, m});
      for (i = 0; i < 7; i++) begin
         fire <= 7'(1 << i);
         @(posedge pclk);
         fire <= 7'h00;
         repeat (8) @(posedge pclk);
         rd(12'h020, 32'(1 << i));
         apb(1'b0, 12'h02C, 32'h0000_0000, r, e);
         chk(32'(r[1]), 32'(m[i]));
         if (m[i]) begin
            cmd(cw(OP_IACK, 1'b0, 7'h00, 3'd0, 1'b0, 5'd0, 2'd0), n);
            rd(12'h028, 32'(i + 1));
         end else begin
            wr(12'h020, 32'(1 << i));
         end
         rd(12'h020, 32'h0000_0000);
      end
      of = 7'($random(seed)) & 7'h1F;
      cmd(cw(OP_TRAP, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
      rd(12'h028, {25'h0, of});
      for (i = 0; i < 4; i++) begin
         acc = $random(seed);
         d = $random(seed);
         pr = {16'h0000, d[15:0]};
         wr(12'h008, acc);
         wr(12'h004, d);
         cmd(cw(OP_SUB, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
         sg = acc >= pr;
         acc = acc - pr;
         rd(12'h008, acc);
         cmd(cw(OP_ADDC, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
         s = 33'(acc) + 33'(pr) + 33'(sg);
         {sg, acc} = s;
         for (int j = 0; j < 4; j++) begin
            cmd(cw(5'(OP_SFL) + 5'((j + 2) % 4), 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
            case ((j + 2) % 4)
               0: {sg, acc} = {acc, 1'b0};
               1: {acc, sg} = {1'b0, acc};
               2: {sg, acc} = {acc, sg};
               default: {acc, sg} = {sg, acc};
            endcase
            rd(12'h008, acc);
            apb(1'b0, 12'h010, 32'h0000_0000, r, e);
            chk(32'(r[9]), 32'(sg));
         end
         wr(12'h044, {16'h0000, 8'hFE, d[7:0]});
         cmd(cw(OP_PWR, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
         chk(32'(n), 32'd1);
         wr(12'h008, 32'h0000_0000);
         cmd(cw(OP_PRD, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
         rd(12'h008, {16'h0000, acc[15:0]});
      end
      wr(12'h000, cw(OP_LAC, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0));
      cmd(cw(OP_ADD, 1'b0, of, 3'd0, 1'b0, 5'd0, 2'd0), n);
      rd(12'h008, 32'({d[15:0], 1'b0}));
      close_out();
   end
endmodule
